//--- core/pic_pkg.sv
// Constants, field layouts and state types of the interrupt output stage
// What this block does
// - Request pin is low-active when polarity bit is 0, high-active when 1; resets 0.
// - Enable register holds system, converter and GPIO group enables, all 0 at reset.
// - Enable bit 4 gates GPIO-group requests onto the request pin.
// - Enable bit 1 gates converter-group requests onto the request pin.
// - Monitor register is read-only, writes ignored, reads zero after reset.
// - Monitor bit 5 shows a pending watchdog request.
// - Monitor bit 4 shows any pending GPIO-group request.
// - Monitor bit 1 shows any pending converter-group request.
// - Monitor bit 0 shows any pending system-group request.
// - Predetect register: bit 2 picks range, bits 1:0 pick level; default code 5.
// - Falling 2.7-3.0 V or 3.2-3.5 V; rising 50 or 100 mV higher.
// - Supply crossing the predetect threshold raises a system-group request.
// - Overheat field picks 105/85, 115/95, 125/105 or 135/115 degrees C.
// - Overheat detection raises a request; register at BCh, default code 2.
package pic_pkg;
   // Register offsets
   localparam logic [7:0] REG_PIN_POLARITY = 8'h9c;
   localparam logic [7:0] REG_GROUP_ENABLE = 8'h9d;
   localparam logic [7:0] REG_GROUP_MONITOR = 8'h9e;
   localparam logic [7:0] REG_PREDETECT = 8'hb0;
   localparam logic [7:0] REG_OVERHEAT = 8'hbc;
   localparam logic [7:0] REG_SYS_EVENT = 8'hbe;
   // Field positions
   localparam int BIT_POLARITY = 0;
   localparam int BIT_SYSTEM = 0;
   localparam int BIT_CONVERTER = 1;
   localparam int BIT_GPIO = 4;
   localparam int BIT_WATCHDOG = 5;
   localparam int BIT_PREDET_RANGE = 2;
   localparam int EV_PREDETECT = 0;
   localparam int EV_OVERHEAT = 1;
   // Reset values
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_MONITOR = 8'h00;
   localparam logic [7:0] RST_PREDETECT = 8'h05;
   localparam logic [7:0] RST_OVERHEAT = 8'h02;
   // Thresholds in mV and degrees C
   localparam logic [12:0] PRE_LO_BASE_MV = 13'h0a8c;
   localparam logic [12:0] PRE_HI_BASE_MV = 13'h0c80;
   localparam logic [12:0] PRE_STEP_MV = 13'h0064;
   localparam logic [12:0] PRE_LO_HYST_MV = 13'h0032;
   localparam logic [12:0] PRE_HI_HYST_MV = 13'h0064;
   localparam logic [7:0] OVT_DET_BASE_C = 8'h69;
   localparam logic [7:0] OVT_REC_BASE_C = 8'h55;
   localparam logic [7:0] OVT_STEP_C = 8'h0a;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_REG = 4'b0011,
      ST_REG_ACK = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_RACK = 4'b1000
   } pic_i2c_st_t;

   typedef struct packed {
      pic_i2c_st_t st;
      logic scl_q;
      logic sda_q;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic [7:0] ptr;
      logic sda_oe;
      logic sda_o;
      logic [7:0] polarity;
      logic [7:0] enable;
      logic [7:0] monitor;
      logic [7:0] predetect;
      logic [7:0] overheat;
      logic [1:0] sys_event;
      logic irq_pin;
   } pic_top_st_t;

   typedef struct packed {
      logic active;
      logic event_p;
   } pic_det_st_t;

   typedef struct packed {
      logic meta;
      logic rstn;
   } pic_rst_st_t;
endpackage

//--- core/pic_rst_sync.sv
// Two-stage release of the asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module pic_rst_sync
   import pic_pkg::*;
(
   // Clock and raw reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Released reset
   output logic o_rstn
);
   pic_rst_st_t r;
   pic_rst_st_t next_r;

   always_comb begin
      next_r.meta = 1'b1;
      // First stage feeds only the second stage
      next_r.rstn = r.meta;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_rstn = r.rstn;
endmodule
`default_nettype wire

//--- core/pic_hyst_det.sv
// Threshold detector with separate set and release levels
`timescale 1ns/10ps
`default_nettype none
module pic_hyst_det
   import pic_pkg::*;
#(
   parameter int W = 13,
   parameter bit HIGH_SIDE = 1'b0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Measured value and levels
   input wire logic [W-1:0] i_value,
   input wire logic [W-1:0] i_set_thr,
   input wire logic [W-1:0] i_clr_thr,
   // Result
   output logic o_active,
   output logic o_event
);
   pic_det_st_t r;
   pic_det_st_t next_r;
   logic hit;
   logic back;

   if (W < 8 || W > 16) begin : g_bad_width
      $error("pic_hyst_det: W must lie in 8..16");
   end

   assign hit = HIGH_SIDE ? (i_value >= i_set_thr) : (i_value <= i_set_thr);
   assign back = HIGH_SIDE ? (i_value <= i_clr_thr) : (i_value >= i_clr_thr);

   always_comb begin
      next_r = r;
      next_r.event_p = 1'b0;
      // Gap between levels stops chatter near the threshold
      if (!r.active && hit) begin
         next_r.active = 1'b1;
         next_r.event_p = 1'b1;
      end else if (r.active && back) begin
         next_r.active = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_active = r.active;
   assign o_event = r.event_p;
endmodule
`default_nettype wire

//--- core/pic_irq_out_ctrl.sv
// Interrupt output stage with its two-wire register port
`timescale 1ns/10ps
`default_nettype none
module pic_irq_out_ctrl
   import pic_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h36
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Two-wire register port, data pin is open drain
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Group request levels from the source blocks
   input wire logic i_sys_pending,
   input wire logic i_conv_pending,
   input wire logic i_gpio_pending,
   input wire logic i_wdg_pending,
   // Measurements
   input wire logic [12:0] i_supply_mv,
   input wire logic [7:0] i_die_temp_c,
   // Interrupt request pin
   output logic o_irq_request_pin
);
   pic_top_st_t r;
   pic_top_st_t next_r;
   logic rstn;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [12:0] pre_fall_mv;
   logic [12:0] pre_rise_mv;
   logic [7:0] ovt_det_c;
   logic [7:0] ovt_rec_c;
   logic supply_low;
   logic supply_ev;
   logic overheat;
   logic overheat_ev;
   logic [2:0] grp_gate;

   if (SLAVE_ADDR == 7'h00) begin : g_bad_addr
      $error("pic_irq_out_ctrl: general call address not allowed");
   end

   if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hf) begin : g_rsv_addr
      $error("pic_irq_out_ctrl: reserved two-wire address not allowed");
   end

   pic_rst_sync u_rst (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .o_rstn(rstn)
   );

   // Predetect threshold from range and level
   always_comb begin
      if (r.predetect[BIT_PREDET_RANGE]) begin
         pre_fall_mv = PRE_HI_BASE_MV + 13'(PRE_STEP_MV * r.predetect[1:0]);
         pre_rise_mv = pre_fall_mv + PRE_HI_HYST_MV;
      end else begin
         pre_fall_mv = PRE_LO_BASE_MV + 13'(PRE_STEP_MV * r.predetect[1:0]);
         pre_rise_mv = pre_fall_mv + PRE_LO_HYST_MV;
      end
   end

   // Overheat detect and recovery levels
   assign ovt_det_c = OVT_DET_BASE_C + 8'(OVT_STEP_C * r.overheat[1:0]);
   assign ovt_rec_c = OVT_REC_BASE_C + 8'(OVT_STEP_C * r.overheat[1:0]);

   pic_hyst_det #(
      .W(13),
      .HIGH_SIDE(1'b0)
   ) u_supply_det (
      .i_clk(i_clk),
      .i_rstn(rstn),
      .i_value(i_supply_mv),
      .i_set_thr(pre_fall_mv),
      .i_clr_thr(pre_rise_mv),
      .o_active(supply_low),
      .o_event(supply_ev)
   );

   pic_hyst_det #(
      .W(8),
      .HIGH_SIDE(1'b1)
   ) u_temp_det (
      .i_clk(i_clk),
      .i_rstn(rstn),
      .i_value(i_die_temp_c),
      .i_set_thr(ovt_det_c),
      .i_clr_thr(ovt_rec_c),
      .o_active(overheat),
      .o_event(overheat_ev)
   );

   // Line events, inputs are already synchronous
   assign scl_rise = i_scl & ~r.scl_q;
   assign scl_fall = ~i_scl & r.scl_q;
   assign start_cond = i_scl & r.scl_q & r.sda_q & ~i_sda;
   assign stop_cond = i_scl & r.scl_q & ~r.sda_q & i_sda;

   // Watchdog has no gate, so it only ever shows in the monitor
   for (genvar g = 0; g < 3; g++) begin : g_gate
      localparam int POS = (g == 0) ? BIT_SYSTEM : ((g == 1) ? BIT_CONVERTER : BIT_GPIO);
      assign grp_gate[g] = r.monitor[POS] & r.enable[POS];
   end

   // Read view of the register map
   function automatic logic [7:0] rd_reg(input pic_top_st_t s, input logic [7:0] a);
      case (a)
         REG_PIN_POLARITY: begin
            rd_reg = s.polarity;
         end
         REG_GROUP_ENABLE: begin
            rd_reg = s.enable;
         end
         REG_GROUP_MONITOR: begin
            rd_reg = s.monitor;
         end
         REG_PREDETECT: begin
            rd_reg = s.predetect;
         end
         REG_OVERHEAT: begin
            rd_reg = s.overheat;
         end
         REG_SYS_EVENT: begin
            rd_reg = {6'h00, s.sys_event};
         end
         default: begin
            rd_reg = 8'h00;
         end
      endcase
   endfunction

   always_comb begin
      logic [1:0] ev_clr;
      logic [1:0] ev_set;
      logic [7:0] mon;
      logic active;
      ev_clr = 2'b00;
      ev_set = 2'b00;
      mon = RST_MONITOR;
      active = 1'b0;
      next_r = r;
      next_r.scl_q = i_scl;
      next_r.sda_q = i_sda;
      next_r.sda_o = 1'b0;

      if (start_cond) begin
         // Repeated start also lands here
         next_r.st = ST_ADDR;
         next_r.bitcnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop_cond) begin
         next_r.st = ST_IDLE;
         next_r.sda_oe = 1'b0;
      end else begin
         case (r.st)
            ST_IDLE: begin
               next_r.sda_oe = 1'b0;
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  next_r.shreg = {r.shreg[6:0], i_sda};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == 4'h8) begin
                  next_r.bitcnt = 4'h0;
                  next_r.sda_oe = 1'b1;
                  if (r.st == ST_ADDR) begin
                     if (r.shreg[7:1] == SLAVE_ADDR) begin
                        next_r.rw = r.shreg[0];
                        next_r.st = ST_ADDR_ACK;
                     end else begin
                        // Not ours, stay off the line
                        next_r.sda_oe = 1'b0;
                        next_r.st = ST_IDLE;
                     end
                  end else if (r.st == ST_REG) begin
                     next_r.ptr = r.shreg;
                     next_r.st = ST_REG_ACK;
                  end else begin
                     case (r.ptr)
                        REG_PIN_POLARITY: begin
                           next_r.polarity = r.shreg;
                        end
                        REG_GROUP_ENABLE: begin
                           next_r.enable = r.shreg;
                        end
                        REG_PREDETECT: begin
                           next_r.predetect = r.shreg;
                        end
                        REG_OVERHEAT: begin
                           next_r.overheat = r.shreg;
                        end
                        REG_SYS_EVENT: begin
                           ev_clr = r.shreg[1:0];
                        end
                        // Monitor and unmapped offsets drop the byte
                        default: begin
                           ev_clr = 2'b00;
                        end
                     endcase
                     next_r.ptr = r.ptr + 8'h01;
                     next_r.st = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_r.bitcnt = 4'h0;
                  if (r.rw) begin
                     next_r.shreg = rd_reg(r, r.ptr);
                     next_r.sda_oe = ~next_r.shreg[7];
                     next_r.st = ST_RDATA;
                  end else begin
                     next_r.sda_oe = 1'b0;
                     next_r.st = ST_REG;
                  end
               end
            end
            ST_REG_ACK, ST_WDATA_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bitcnt = 4'h0;
                  next_r.st = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (r.bitcnt == 4'h7) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st = ST_RACK;
                  end else begin
                     next_r.shreg = {r.shreg[6:0], 1'b0};
                     next_r.sda_oe = ~r.shreg[6];
                     next_r.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && i_sda) begin
                  // Not acknowledged, master ends the read
                  next_r.st = ST_IDLE;
               end else if (scl_fall) begin
                  next_r.ptr = r.ptr + 8'h01;
                  next_r.shreg = rd_reg(r, r.ptr + 8'h01);
                  next_r.sda_oe = ~next_r.shreg[7];
                  next_r.bitcnt = 4'h0;
                  next_r.st = ST_RDATA;
               end
            end
            default: begin
               next_r.st = ST_IDLE;
               next_r.sda_oe = 1'b0;
            end
         endcase
      end

      // Sticky detector events, a new event beats a clear
      ev_set[EV_PREDETECT] = supply_ev;
      ev_set[EV_OVERHEAT] = overheat_ev;
      next_r.sys_event = (r.sys_event & ~ev_clr) | ev_set;

      // Group view, only hardware drives it
      mon[BIT_WATCHDOG] = i_wdg_pending;
      mon[BIT_GPIO] = i_gpio_pending;
      mon[BIT_CONVERTER] = i_conv_pending;
      mon[BIT_SYSTEM] = i_sys_pending | (|r.sys_event);
      next_r.monitor = mon;

      active = |grp_gate;
      next_r.irq_pin = r.polarity[BIT_POLARITY] ? active : ~active;
   end

   always_ff @(posedge i_clk or negedge rstn) begin
      if (!rstn) begin
         r.st <= ST_IDLE;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.bitcnt <= 4'h0;
         r.shreg <= 8'h00;
         r.rw <= 1'b0;
         r.ptr <= 8'h00;
         r.sda_oe <= 1'b0;
         r.sda_o <= 1'b0;
         r.polarity <= RST_POLARITY;
         r.enable <= RST_ENABLE;
         r.monitor <= RST_MONITOR;
         r.predetect <= RST_PREDETECT;
         r.overheat <= RST_OVERHEAT;
         r.sys_event <= 2'b00;
         // Low-active default, so idle level is high
         r.irq_pin <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign o_sda_o = r.sda_o;
   assign o_sda_oe = r.sda_oe;
   assign o_irq_request_pin = r.irq_pin;
endmodule
`default_nettype wire

//--- core/dummy_never_used_placeholder_removed.sv
// Intentionally empty
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- verif/pic_irq_out_ctrl_checker.sv
// Port-level assertions of the interrupt output stage
`timescale 1ns/10ps
`default_nettype none
module pic_irq_out_ctrl_checker (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Watched ports
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   input wire logic i_sys_pending,
   input wire logic i_conv_pending,
   input wire logic i_gpio_pending,
   input wire logic i_wdg_pending,
   input wire logic [12:0] i_supply_mv,
   input wire logic [7:0] i_die_temp_c,
   input wire logic o_irq_request_pin
);
   // Watchdog left out of the causes on purpose
   logic [25:0] cause;
   logic [25:0] cause_q;
   logic [3:0] quiet;
   logic [3:0] scl_hi;
   assign cause = {i_scl, i_sda, i_sys_pending, i_conv_pending, i_gpio_pending,
      i_supply_mv, i_die_temp_c};
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cause_q <= '0;
         quiet <= 4'h0;
         scl_hi <= 4'h0;
      end else begin
         cause_q <= cause;
         quiet <= (cause != cause_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
         scl_hi <= !i_scl ? 4'h0 : ((scl_hi == 4'hf) ? scl_hi : scl_hi + 4'h1);
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   reset_idle_a: assert property ($rose(i_rstn) |-> (o_irq_request_pin && !o_sda_oe) [*2])
      else $error("pin or data enable busy right after reset");
   pin_quiet_a: assert property (quiet >= 4'h8 |-> $stable(o_irq_request_pin))
      else $error("request pin moved without a cause");
   sda_out_zero_a: assert property (o_sda_o == 1'b0)
      else $error("data pin drives high");
   oe_rise_low_a: assert property ($rose(o_sda_oe) |-> !$past(i_scl) && !i_scl ##1 o_sda_oe [*3])
      else $error("data enable rose off the clock low phase");
   oe_fall_low_a: assert property ($fell(o_sda_oe) |-> !$past(i_scl) && !i_scl)
      else $error("data enable fell off the clock low phase");
   oe_hold_high_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("data enable moved while clock high");
   bus_idle_free_a: assert property (scl_hi >= 4'h8 |-> !o_sda_oe)
      else $error("data pulled low on an idle bus");
   start_no_drive_a: assert property ($fell(i_sda) && i_scl && $past(i_scl) |->
      !o_sda_oe ##1 !o_sda_oe [*8])
      else $error("data driven during address bits");
endmodule
bind pic_irq_out_ctrl pic_irq_out_ctrl_checker pic_irq_out_ctrl_checker_inst (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o),
   .o_sda_oe(o_sda_oe), .i_sys_pending(i_sys_pending), .i_conv_pending(i_conv_pending),
   .i_gpio_pending(i_gpio_pending), .i_wdg_pending(i_wdg_pending),
   .i_supply_mv(i_supply_mv), .i_die_temp_c(i_die_temp_c),
   .o_irq_request_pin(o_irq_request_pin));
`default_nettype wire

//--- verif/pic_host_model.sv
// Host side: two-wire register master
`timescale 1ns/10ps
`default_nettype none
module pic_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h36
) (
   // Clock and resolved data wire
   input wire logic i_clk,
   input wire logic i_sda,
   // Master drive, data is open drain
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Four clocks low, five high, keeps data well clear of clock edges
   task automatic clk_bit(input logic b, output logic got);
      tick(1);
      o_scl = 1'b0;
      tick(2);
      o_sda_low = !b;
      tick(2);
      o_scl = 1'b1;
      tick(2);
      got = i_sda;
      tick(2);
   endtask
   task automatic start_cond();
      logic b;
      clk_bit(1'b1, b);
      o_sda_low = 1'b1;
      tick(3);
   endtask
   task automatic stop_cond();
      logic b;
      clk_bit(1'b0, b);
      o_sda_low = 1'b0;
      tick(3);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], b);
         q[i] = b;
      end
      clk_bit(1'b1, b);
      ack = !b;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start_cond();
      xfer({a, 1'b0}, q, k0);
      xfer(r, q, k1);
      xfer(d, q, k2);
      stop_cond();
      ok = k0 & k1 & k2;
   endtask
   // Single byte read, closed by a not-acknowledge
   task automatic rd(input logic [7:0] r, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start_cond();
      xfer({DEV_ADDR, 1'b0}, q, k0);
      xfer(r, q, k1);
      start_cond();
      xfer({DEV_ADDR, 1'b1}, q, k2);
      // Released bits let the device drive, the ninth clock is the NACK
      xfer(8'hff, d, k3);
      stop_cond();
      ok = k0 & k1 & k2 & !k3;
   endtask
endmodule
`default_nettype wire

//--- verif/pic_irq_out_ctrl_tb_top.sv
// Self-checking bench of the interrupt output stage
`timescale 1ns/10ps
`default_nettype none
module pic_irq_out_ctrl_tb_top
   import pic_pkg::*;
;
   typedef struct packed {
      logic [7:0] en;
      logic pol;
      logic [3:0] pend;
      logic [7:0] mon;
      logic pin;
   } pic_row_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic scl, sda_low, sda, sda_o, sda_oe, pin, ok;
   logic [3:0] pend = 4'h0;
   logic [12:0] supply = 13'h0e10;
   logic [7:0] temp = 8'h19;
   logic [7:0] rdv;
   int mismatches = 0;
   int tests_run = 0;
   // Pending order is watchdog, GPIO, converter, system
   pic_row_t rows [8] = '{
      '{8'h00, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h13, 1'b0, 4'h1, 8'h01, 1'b0},
      '{8'h13, 1'b1, 4'h2, 8'h02, 1'b1}, '{8'h10, 1'b0, 4'h4, 8'h10, 1'b0},
      '{8'h02, 1'b0, 4'h4, 8'h10, 1'b1}, '{8'h13, 1'b1, 4'h8, 8'h20, 1'b0},
      '{8'h01, 1'b1, 4'h6, 8'h12, 1'b0}, '{8'hec, 1'b0, 4'h7, 8'h13, 1'b1}};
   assign sda = !(sda_low | sda_oe);
   always #2.5 clk = !clk;
   pic_irq_out_ctrl pic_irq_out_ctrl_inst (.i_clk(clk), .i_rstn(rstn), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_sys_pending(pend[0]),
      .i_conv_pending(pend[1]), .i_gpio_pending(pend[2]), .i_wdg_pending(pend[3]),
      .i_supply_mv(supply), .i_die_temp_c(temp), .o_irq_request_pin(pin));
   pic_host_model pic_host_model_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic put(input logic [7:0] r, input logic [7:0] d);
      pic_host_model_inst.wr(7'h36, r, d, ok);
      chk({7'h0, ok}, 8'h01);
   endtask
   task automatic get(input logic [7:0] r, input logic [7:0] exp);
      pic_host_model_inst.rd(r, rdv, ok);
      chk({7'h0, ok}, 8'h01);
      chk(rdv, exp);
   endtask
   task automatic pin_is(input logic v);
      repeat (8) @(negedge clk);
      chk({7'h0, pin}, {7'h0, v});
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      foreach (rows[k]) begin
         put(REG_PIN_POLARITY, {7'h0, rows[k].pol});
         put(REG_GROUP_ENABLE, rows[k].en);
         pend = rows[k].pend;
         pin_is(rows[k].pin);
         get(REG_GROUP_MONITOR, rows[k].mon);
      end
      // Monitor write must be dropped
      pend = 4'hf;
      put(REG_GROUP_MONITOR, 8'h00);
      get(REG_GROUP_MONITOR, 8'h33);
      pend = 4'h0;
      get(8'ha0, 8'h00);
      // Foreign address is ignored whole
      pic_host_model_inst.wr(7'h37, REG_GROUP_ENABLE, 8'h00, ok);
      chk({7'h0, ok}, 8'h00);
      get(REG_GROUP_ENABLE, 8'hec);
      // Lowest range, top level: falls at 3000 mV
      put(REG_GROUP_ENABLE, 8'h01);
      put(REG_PREDETECT, 8'h03);
      get(REG_PREDETECT, 8'h03);
      supply = 13'h0bb9;
      pin_is(1'b1);
      supply = 13'h0bb8;
      pin_is(1'b0);
      get(REG_GROUP_MONITOR, 8'h01);
      put(REG_SYS_EVENT, 8'h01);
      supply = 13'h0e10;
      pin_is(1'b1);
      // Lowest overheat step detects at 105
      put(REG_OVERHEAT, 8'h00);
      temp = 8'h68;
      pin_is(1'b1);
      temp = 8'h69;
      pin_is(1'b0);
      get(REG_SYS_EVENT, 8'h02);
      temp = 8'h19;
      put(REG_SYS_EVENT, 8'h02);
      pin_is(1'b1);
      // Second reset in mid-run restores defaults
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      get(REG_PIN_POLARITY, 8'h00);
      get(REG_GROUP_ENABLE, 8'h00);
      get(REG_GROUP_MONITOR, 8'h00);
      get(REG_PREDETECT, 8'h05);
      get(REG_OVERHEAT, 8'h02);
      report_and_stop();
   end
endmodule
`default_nettype wire
